// ---- rtl/raster_sequencer.sv ----
// Triggered raster scan sequencer driving one scanner axis controller.
module raster_sequencer (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_id_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic param_valid_in,
    input wire logic [7:0] param_id_in,
    input wire logic [15:0] param_data_in,
    input wire logic trigger_input_line_in,
    input wire logic position_done_in,
    input wire logic stroke_done_in,
    output logic position_start_out,
    output logic stroke_start_out,
    output logic stroke_reverse_out,
    output logic scanning_out,
    output logic [1:0] armed_mode_out,
    output logic [15:0] scan_time_out,
    output logic [15:0] duty_ratio_out,
    output logic [15:0] scan_angle_out,
    output logic trigger_dropped_out
);
    typedef struct packed {
        raster_pkg::seq_e state;
        raster_pkg::arm_e arm;
        logic position_start;
        logic stroke_start;
        logic reverse;
        logic dropped;
        logic [15:0] scan_time;
        logic [15:0] duty;
        logic [15:0] angle;
    } seq_s;

    seq_s st_r;
    seq_s st_nxt;

    trig_if trig ();

    trig_sync u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .trigger_input_line_in(trigger_input_line_in),
        .trig(trig)
    );

    function automatic logic is_cmd(input logic [7:0] id, input logic [15:0] data,
                                    input logic [7:0] want_id, input logic [15:0] want_data);
        is_cmd = cmd_valid_in && (id == want_id) && (data == want_data);
    endfunction : is_cmd

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.position_start = 1'b0;
        st_nxt.stroke_start = 1'b0;
        st_nxt.dropped = 1'b0;
        if (param_valid_in)
        begin
            case (param_id_in)
                raster_pkg::PARAM_SCAN_TIME: st_nxt.scan_time = param_data_in;
                raster_pkg::PARAM_DUTY: st_nxt.duty = param_data_in;
                raster_pkg::PARAM_ANGLE: st_nxt.angle = param_data_in;
                default: st_nxt.scan_time = st_r.scan_time;
            endcase
        end
        case (st_r.state)
            raster_pkg::ST_IDLE:
            begin
                if (is_cmd(cmd_id_in, cmd_data_in, raster_pkg::CMD_MOVE_START,
                           raster_pkg::MOVE_TO_START))
                begin
                    st_nxt.position_start = 1'b1;
                    st_nxt.state = raster_pkg::ST_POSITION;
                end
            end
            raster_pkg::ST_POSITION:
            begin
                if (position_done_in)
                begin
                    st_nxt.state = raster_pkg::ST_WAIT_TRIG;
                end
            end
            raster_pkg::ST_WAIT_TRIG:
            begin
                if (st_r.arm == raster_pkg::ARM_CONTINUOUS)
                begin
                    st_nxt.stroke_start = 1'b1;
                    st_nxt.reverse = 1'b0;
                    st_nxt.state = raster_pkg::ST_FORWARD;
                end
                else if (trig.rise && st_r.arm != raster_pkg::ARM_NONE)
                begin
                    st_nxt.stroke_start = 1'b1;
                    st_nxt.reverse = 1'b0;
                    st_nxt.state = raster_pkg::ST_FORWARD;
                end
            end
            raster_pkg::ST_FORWARD:
            begin
                if (trig.rise)
                begin
                    st_nxt.dropped = 1'b1;
                end
                if (stroke_done_in)
                begin
                    if (st_r.arm == raster_pkg::ARM_ONE_WAY)
                    begin
                        st_nxt.state = raster_pkg::ST_WAIT_TRIG;
                    end
                    else
                    begin
                        st_nxt.stroke_start = 1'b1;
                        st_nxt.reverse = 1'b1;
                        st_nxt.state = raster_pkg::ST_BACKWARD;
                    end
                end
            end
            raster_pkg::ST_BACKWARD:
            begin
                if (trig.rise)
                begin
                    st_nxt.dropped = 1'b1;
                end
                if (stroke_done_in)
                begin
                    st_nxt.reverse = 1'b0;
                    st_nxt.state = raster_pkg::ST_WAIT_TRIG;
                end
            end
            default:
            begin
                st_nxt.state = raster_pkg::ST_IDLE;
            end
        endcase
        if (cmd_valid_in && cmd_id_in == raster_pkg::CMD_OP_MODE)
        begin
            case (cmd_data_in)
                raster_pkg::MODE_ONE_WAY: st_nxt.arm = raster_pkg::ARM_ONE_WAY;
                raster_pkg::MODE_ROUND_TRIP: st_nxt.arm = raster_pkg::ARM_ROUND_TRIP;
                raster_pkg::MODE_CONTINUOUS: st_nxt.arm = raster_pkg::ARM_CONTINUOUS;
                raster_pkg::MODE_STOP:
                begin
                    st_nxt.arm = raster_pkg::ARM_NONE;
                    st_nxt.stroke_start = 1'b0;
                    st_nxt.reverse = 1'b0;
                    st_nxt.state = raster_pkg::ST_IDLE;
                end
                default: st_nxt.arm = st_r.arm;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign position_start_out = st_r.position_start;
    assign stroke_start_out = st_r.stroke_start;
    assign stroke_reverse_out = st_r.reverse;
    assign scanning_out = (st_r.state == raster_pkg::ST_FORWARD) ||
                          (st_r.state == raster_pkg::ST_BACKWARD);
    assign armed_mode_out = st_r.arm;
    assign scan_time_out = st_r.scan_time;
    assign duty_ratio_out = st_r.duty;
    assign scan_angle_out = st_r.angle;
    assign trigger_dropped_out = st_r.dropped;
endmodule : raster_sequencer

// ---- shared/raster_pkg.sv ----
// Package with command codes, modes, states and timing constants for the raster sequencer.
package raster_pkg;

    localparam logic [7:0] CMD_MOVE_START = 8'h08;
    localparam logic [7:0] CMD_OP_MODE = 8'h17;
    localparam logic [15:0] MOVE_TO_START = 16'h0006;
    localparam logic [15:0] MODE_STOP = 16'h0000;
    localparam logic [15:0] MODE_CONTINUOUS = 16'h0003;
    localparam logic [15:0] MODE_ONE_WAY = 16'h0008;
    localparam logic [15:0] MODE_ROUND_TRIP = 16'h0009;

    localparam logic [7:0] PARAM_SCAN_TIME = 8'h1a;
    localparam logic [7:0] PARAM_DUTY = 8'h1b;
    localparam logic [7:0] PARAM_ANGLE = 8'h1c;

    localparam int CLK_HZ = 10000000;
    localparam int MAX_TRIG_JITTER_NS = 10000;
    localparam int MAX_TRIG_JITTER_CYC = (MAX_TRIG_JITTER_NS * (CLK_HZ / 1000000)) / 1000;

    typedef enum logic [1:0] {
        ARM_NONE,
        ARM_ONE_WAY,
        ARM_ROUND_TRIP,
        ARM_CONTINUOUS
    } arm_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POSITION,
        ST_WAIT_TRIG,
        ST_FORWARD,
        ST_BACKWARD
    } seq_e;

endpackage : raster_pkg

// ---- shared/trig_if.sv ----
// Interface carrying the synchronised trigger event between the sequencer modules.
interface trig_if;
    logic level;
    logic rise;
    modport source (output level, output rise);
    modport sink (input level, input rise);
endinterface : trig_if

// ---- rtl/trig_sync.sv ----
// Trigger synchroniser with three flip-flops and rising-edge detection.
module trig_sync (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic trigger_input_line_in,
    trig_if.source trig
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = trigger_input_line_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.level = st_r.s3;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign trig.level = st_r.level;
    assign trig.rise = st_nxt.level & ~st_r.level;
endmodule : trig_sync

// ---- test/raster_sequencer_props.sv ----
// Port assertions for the raster sequencer.
module raster_sequencer_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_id_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic trigger_input_line_in,
    input wire logic stroke_done_in,
    input wire logic position_start_out,
    input wire logic stroke_start_out,
    input wire logic stroke_reverse_out,
    input wire logic scanning_out,
    input wire logic [1:0] armed_mode_out,
    input wire logic trigger_dropped_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic op;
    logic mv;
    assign op = cmd_valid_in && cmd_id_in == 8'h17;
    assign mv = cmd_valid_in && cmd_id_in == 8'h08 && cmd_data_in == 16'h0006;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    property p_pos; position_start_out |-> $past(mv); endproperty
    a_pos: assert property (p_pos) else $error("bad move start");
    property p_one; op && cmd_data_in == 16'h0008 |=> armed_mode_out == 2'h1; endproperty
    a_one: assert property (p_one) else $error("bad one-way arm");
    property p_cont; op && cmd_data_in == 16'h0003 |=> armed_mode_out == 2'h3; endproperty
    a_cont: assert property (p_cont) else $error("bad continuous arm");
    property p_stop; op && cmd_data_in == 16'h0 |=> armed_mode_out == 2'h0 && !scanning_out;
    endproperty
    a_stop: assert property (p_stop) else $error("bad stop");
    property p_drop; trigger_dropped_out |-> $past(scanning_out); endproperty
    a_drop: assert property (p_drop) else $error("bad drop");
    property p_lat; stroke_start_out && !stroke_reverse_out && armed_mode_out inside {2'h1, 2'h2}
        |-> $past(trigger_input_line_in, 2); endproperty
    a_lat: assert property (p_lat) else $error("bad trigger start");
    property p_bk; stroke_done_in && scanning_out && !stroke_reverse_out && armed_mode_out == 2'h2
        |=> stroke_start_out && stroke_reverse_out; endproperty
    a_bk: assert property (p_bk) else $error("bad return stroke");
    property p_ow; stroke_done_in && scanning_out && armed_mode_out == 2'h1 |=> !scanning_out;
    endproperty
    a_ow: assert property (p_ow) else $error("bad one-way end");
    property p_two; op && cmd_data_in == 16'h0009 |=> armed_mode_out == 2'h2; endproperty
    a_two: assert property (p_two) else $error("bad round-trip arm");
    property p_norst; scanning_out && !stroke_done_in |=> !stroke_start_out; endproperty
    a_norst: assert property (p_norst) else $error("stroke restarted while moving");
    property p_noarm; armed_mode_out == 2'h0 |-> !stroke_start_out; endproperty
    a_noarm: assert property (p_noarm) else $error("stroke started while unarmed");
    c_bk: cover property (stroke_start_out && stroke_reverse_out);
    c_drop: cover property (trigger_dropped_out);
    c_cont: cover property (stroke_start_out && armed_mode_out == 2'h3);
endmodule : raster_sequencer_props
bind raster_sequencer raster_sequencer_props u_props (.*);

// ---- test/axis_model.sv ----
// Axis controller model answering a start pulse with a done pulse after a lag.
module axis_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [3:0] lag_in,
    output logic done_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_r = 5'h00;
    always_ff @(posedge clk_in)
    begin
        done_out <= cnt_r == 5'h01;
        cnt_r <= start_in ? {1'b0, lag_in} + 5'h02 : cnt_r - 5'(cnt_r != 5'h00);
    end
endmodule : axis_model

// ---- test/tb_top.sv ----
// Self-checking bench for the raster sequencer.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, reset_in = 1, cv = 0, pv = 0, trig = 0, pgo, pdn, sgo, sdn, rev, scan, drop;
    logic [7:0] id = 0;
    logic [15:0] dat = 0, rnd = 16'hcb8a, tm, du, an;
    logic [15:0] modes [4] = '{16'h8, 16'h9, 16'h3, 16'h0};
    logic [3:0] lag = 0;
    logic [1:0] arm;
    int err_total = 0, tests_run = 0, n_st = 0, n_rev = 0, n_drop = 0, n_pos = 0, k;
    raster_sequencer u_dut (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cv),
        .cmd_id_in(id), .cmd_data_in(dat), .param_valid_in(pv), .param_id_in(id),
        .param_data_in(dat), .trigger_input_line_in(trig), .position_done_in(pdn),
        .stroke_done_in(sdn), .position_start_out(pgo), .stroke_start_out(sgo),
        .stroke_reverse_out(rev), .scanning_out(scan), .armed_mode_out(arm),
        .scan_time_out(tm), .duty_ratio_out(du), .scan_angle_out(an), .trigger_dropped_out(drop));
    axis_model u_pos (.clk_in(clk_in), .start_in(pgo), .lag_in(lag), .done_out(pdn));
    axis_model u_st (.clk_in(clk_in), .start_in(sgo), .lag_in(lag), .done_out(sdn));
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        n_st += int'(sgo === 1'b1);
        n_rev += int'(sgo === 1'b1 && rev === 1'b1);
        n_drop += int'(drop === 1'b1);
        n_pos += int'(pgo === 1'b1);
    end
    function automatic logic [15:0] exp_arm(input logic [15:0] d);
        return (d == 16'h3) ? 16'h3 : (d > 16'h7) ? d - 16'h7 : 16'h0;
    endfunction : exp_arm
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input logic p, input logic [7:0] i, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        {pv, cv, id, dat} = {p, !p, i, d};
        @(posedge clk_in);
        #1;
        {pv, cv} = 2'h0;
        rnd = lfsr_next(rnd);
        lag = rnd[3:0];
    endtask : send
    task automatic fire(input int hold);
        @(posedge clk_in);
        #1;
        trig = 1;
        repeat (hold) @(posedge clk_in);
        #1;
        trig = 0;
    endtask : fire
    task automatic wrap_up();
        $display("mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 0;
        check({14'h0, arm}, 16'h0);
        send(1, 8'h1a, rnd);
        check(tm, dat);
        send(1, 8'h1b, rnd);
        check(du, dat);
        send(1, 8'h1c, rnd);
        check(an, dat);
        foreach (modes[j])
        begin
            send(0, 8'h17, modes[j]);
            check({14'h0, arm}, exp_arm(modes[j]));
        end
        send(0, 8'h08, 16'h0006);
        repeat (20) @(posedge clk_in);
        send(0, 8'h08, 16'h0006);
        check(16'(n_pos), 16'h1);
        send(0, 8'h17, 16'h0008);
        lag = 4'hf;
        fire(6);
        repeat (2) @(posedge clk_in);
        fire(2);
        repeat (30) @(posedge clk_in);
        check(16'(n_st), 16'h1);
        check(16'(n_drop), 16'h1);
        send(0, 8'h17, 16'h0009);
        fire(6);
        repeat (40) @(posedge clk_in);
        check(16'(n_st), 16'h3);
        check(16'(n_rev), 16'h1);
        check({15'h0, rev}, 16'h0);
        check({15'h0, scan}, 16'h0);
        send(0, 8'h17, 16'h0003);
        repeat (40) @(posedge clk_in);
        check(16'(n_st > 4), 16'h1);
        send(0, 8'h17, 16'h0000);
        check({15'h0, scan}, 16'h0);
        k = n_st;
        fire(6);
        repeat (10) @(posedge clk_in);
        check(16'(n_st - k), 16'h0);
        wrap_up();
    end
    initial
    begin
        repeat (2000) @(posedge clk_in);
        err_total++;
        wrap_up();
    end
endmodule : tb_top
